/* File: shared/tcm_pkg.sv */
// Purpose: constants for the 8-bit timer compare block
// Assumes: APB slave, 32-bit data, word-aligned registers
// Notes: register offsets are byte addresses
package tcm_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_COMPARE = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0c;
   localparam logic [7:0] ADDR_PORT = 8'h10;
   // ==========================================
   // control register fields
   localparam int CTRL_CS_LSB = 0;
   localparam int CTRL_WGM_LSB = 3;
   localparam int CTRL_COM_LSB = 5;
   localparam int CTRL_FOC_BIT = 7;
   localparam int CTRL_IE_BIT = 8;
   localparam int CTRL_OVIE_BIT = 9;
   // flag register fields
   localparam int FLAG_CMP_BIT = 0;
   localparam int FLAG_OVF_BIT = 1;
   // port register fields
   localparam int PORT_VAL_BIT = 0;
   localparam int PORT_DIR_BIT = 1;
   localparam int PORT_STATE_BIT = 2;
   // ==========================================
   // waveform modes
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PC_PWM = 2'h1;
   localparam logic [1:0] WGM_CTC = 2'h2;
   localparam logic [1:0] WGM_FAST_PWM = 2'h3;
   // compare output modes
   localparam logic [1:0] COM_NONE = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hff;
   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : tcm_pkg

/* File: design/tcm_timer.sv */
// Purpose: 8-bit timer with output compare, normal/ctc/pwm counting
// Assumes: pclk 250 MHz; prescaler output arrives as a tick per source
// Notes: clk_tick_in is one enable per cs value >0 (index = cs)
//
// Functional notes
// - count equals compare gives match
// - compare flag sets the cycle after
// - flag and enable raise interrupt
// - flag cleared by service or writing one
// - pwm modes double-buffer compare at top
// - cpu accesses buffer or active register
// - force strobe updates output outside pwm modes, no flag
// - count write blocks next match
// - output state kept across mode change
// - output mode bits take effect immediately
// - output mode nonzero overrides port value
// - output mode zero does nothing on match
// - output mode never alters counting
// - normal mode wraps ff to 00
// - normal overflow flag set at zero
// - ctc clears counter after match
// - ctc missed match waits for wrap
// - ctc toggle gives divided frequency
// - ctc overflow set rolling max to zero
// - cpu count write wins over counting
// - clock select zero stops counting
// - mode three is fast pwm
// - mode one is phase-correct pwm
`timescale 1ns/100ps
module tcm_timer #(
   parameter int CNT_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [7:0] clk_tick_in,
   input wire logic compare_irq_ack,
   input wire logic overflow_irq_ack,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic compare_irq,
   output logic overflow_irq,
   output logic compare_pin_out,
   output logic compare_pin_oe
);
   // ==========================================
   // state
   logic [2:0] clock_source_sel_reg, clock_source_sel_next;
   logic [1:0] waveform_mode_sel_reg, waveform_mode_sel_next;
   logic [1:0] compare_output_mode_reg, compare_output_mode_next;
   logic compare_irq_enable_reg, compare_irq_enable_next;
   logic overflow_irq_enable_reg, overflow_irq_enable_next;
   logic [CNT_W-1:0] timer_count_reg, timer_count_next;
   logic [CNT_W-1:0] compare_value_reg, compare_value_next;
   logic [CNT_W-1:0] compare_buf_reg, compare_buf_next;
   logic compare_flag_reg, compare_flag_next;
   logic overflow_flag_reg, overflow_flag_next;
   logic compare_output_state_reg, compare_output_state_next;
   logic count_down_reg, count_down_next;
   logic block_match_reg, block_match_next;
   logic match_pend_reg, match_pend_next;
   logic port_value_reg, port_value_next;
   logic compare_pin_direction_reg, compare_pin_direction_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic compare_irq_reg, compare_irq_next;
   logic overflow_irq_reg, overflow_irq_next;
   logic pin_out_reg, pin_out_next;
   logic pin_oe_reg, pin_oe_next;

   // ==========================================
   // helpers
   function automatic logic is_pwm(input logic [1:0] wgm);
      return (wgm == tcm_pkg::WGM_PC_PWM) || (wgm == tcm_pkg::WGM_FAST_PWM);
   endfunction : is_pwm

   function automatic logic out_action(input logic [1:0] com,
                                       input logic cur);
      unique case (com)
         tcm_pkg::COM_NONE: return cur;
         tcm_pkg::COM_TOGGLE: return ~cur;
         tcm_pkg::COM_CLEAR: return 1'b0;
         tcm_pkg::COM_SET: return 1'b1;
      endcase
   endfunction : out_action

   // ==========================================
   // combinational next state
   logic acc, wr, rd, tick, match, pwm, at_top, at_bottom, hit, ovf_set;
   logic [CNT_W-1:0] top_val, cpu_cmp;
   always_comb begin
      acc = psel && penable && !pready_reg;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      pwm = is_pwm(waveform_mode_sel_reg);
      tick = (clock_source_sel_reg != tcm_pkg::CS_STOP) &&
             clk_tick_in[clock_source_sel_reg];
      match = (timer_count_reg == compare_value_reg);
      hit = match && !block_match_reg;
      top_val = (waveform_mode_sel_reg == tcm_pkg::WGM_CTC) ?
                compare_value_reg : CNT_W'(tcm_pkg::CNT_MAX);
      at_top = (timer_count_reg == top_val);
      at_bottom = (timer_count_reg == CNT_W'(tcm_pkg::CNT_BOTTOM));
      cpu_cmp = pwm ? compare_buf_reg : compare_value_reg;
      ovf_set = 1'b0;

      clock_source_sel_next = clock_source_sel_reg;
      waveform_mode_sel_next = waveform_mode_sel_reg;
      compare_output_mode_next = compare_output_mode_reg;
      compare_irq_enable_next = compare_irq_enable_reg;
      overflow_irq_enable_next = overflow_irq_enable_reg;
      timer_count_next = timer_count_reg;
      compare_value_next = compare_value_reg;
      compare_buf_next = compare_buf_reg;
      compare_flag_next = compare_flag_reg;
      overflow_flag_next = overflow_flag_reg;
      compare_output_state_next = compare_output_state_reg;
      count_down_next = count_down_reg;
      block_match_next = block_match_reg;
      match_pend_next = match_pend_reg;
      port_value_next = port_value_reg;
      compare_pin_direction_next = compare_pin_direction_reg;
      prdata_next = prdata_reg;
      pready_next = acc;
      pslverr_next = 1'b0;

      // ---- counter, on the timer clock enable
      if (tick) begin
         block_match_next = 1'b0;
         match_pend_next = hit;
         if (match_pend_reg)
            compare_flag_next = 1'b1;
         unique case (waveform_mode_sel_reg)
            tcm_pkg::WGM_NORMAL, tcm_pkg::WGM_FAST_PWM: begin
               timer_count_next = timer_count_reg + 1'b1;
               if (timer_count_reg == CNT_W'(tcm_pkg::CNT_MAX)) begin
                  overflow_flag_next = 1'b1;
                  ovf_set = 1'b1;
               end
            end
            tcm_pkg::WGM_CTC: begin
               // no buffering: a compare set below count waits for wrap
               if (hit) begin
                  timer_count_next = CNT_W'(tcm_pkg::CNT_BOTTOM);
               end else begin
                  timer_count_next = timer_count_reg + 1'b1;
               end
               if (timer_count_reg == CNT_W'(tcm_pkg::CNT_MAX)) begin
                  overflow_flag_next = 1'b1;
                  ovf_set = 1'b1;
               end
            end
            tcm_pkg::WGM_PC_PWM: begin
               if (at_top && !count_down_reg) begin
                  count_down_next = 1'b1;
                  timer_count_next = timer_count_reg - 1'b1;
               end else if (at_bottom && count_down_reg) begin
                  count_down_next = 1'b0;
                  timer_count_next = timer_count_reg + 1'b1;
                  overflow_flag_next = 1'b1;
                  ovf_set = 1'b1;
               end else if (count_down_reg) begin
                  timer_count_next = timer_count_reg - 1'b1;
               end else begin
                  timer_count_next = timer_count_reg + 1'b1;
               end
            end
         endcase
         // compare buffer transfer at top (fast) or top turn (pc)
         if (pwm && at_top)
            compare_value_next = compare_buf_reg;
         // output state on match
         if (hit) begin
            if (!pwm) begin
               compare_output_state_next = out_action(
                  compare_output_mode_reg, compare_output_state_reg);
            end else if (compare_output_mode_reg[1]) begin
               compare_output_state_next = compare_output_mode_reg[0] ^
                  ((waveform_mode_sel_reg == tcm_pkg::WGM_PC_PWM) &&
                   count_down_reg);
            end
         end else if (waveform_mode_sel_reg == tcm_pkg::WGM_FAST_PWM &&
                      compare_output_mode_reg[1] &&
                      timer_count_reg == CNT_W'(tcm_pkg::CNT_MAX)) begin
            compare_output_state_next = ~compare_output_mode_reg[0];
         end
      end
      if (compare_irq_ack)
         compare_flag_next = 1'b0;
      if (overflow_irq_ack)
         overflow_flag_next = 1'b0;

      // ---- register writes
      if (wr) begin
         unique case (paddr)
            tcm_pkg::ADDR_CTRL: begin
               clock_source_sel_next = pwdata[tcm_pkg::CTRL_CS_LSB +: 3];
               waveform_mode_sel_next = pwdata[tcm_pkg::CTRL_WGM_LSB +: 2];
               compare_output_mode_next =
                  pwdata[tcm_pkg::CTRL_COM_LSB +: 2];
               compare_irq_enable_next = pwdata[tcm_pkg::CTRL_IE_BIT];
               overflow_irq_enable_next = pwdata[tcm_pkg::CTRL_OVIE_BIT];
               if (pwdata[tcm_pkg::CTRL_FOC_BIT] && !pwm)
                  compare_output_state_next = out_action(
                     pwdata[tcm_pkg::CTRL_COM_LSB +: 2],
                     compare_output_state_reg);
            end
            tcm_pkg::ADDR_COUNT: begin
               timer_count_next = pwdata[CNT_W-1:0];
               block_match_next = 1'b1;
               match_pend_next = 1'b0;
            end
            tcm_pkg::ADDR_COMPARE: begin
               if (pwm)
                  compare_buf_next = pwdata[CNT_W-1:0];
               else begin
                  compare_value_next = pwdata[CNT_W-1:0];
                  compare_buf_next = pwdata[CNT_W-1:0];
               end
            end
            tcm_pkg::ADDR_FLAGS: begin
               // a hardware set in the same cycle wins over the clear
               if (pwdata[tcm_pkg::FLAG_CMP_BIT] &&
                   !(tick && match_pend_reg))
                  compare_flag_next = 1'b0;
               if (pwdata[tcm_pkg::FLAG_OVF_BIT] && !ovf_set)
                  overflow_flag_next = 1'b0;
            end
            tcm_pkg::ADDR_PORT: begin
               port_value_next = pwdata[tcm_pkg::PORT_VAL_BIT];
               compare_pin_direction_next = pwdata[tcm_pkg::PORT_DIR_BIT];
            end
            default: pslverr_next = 1'b1;
         endcase
      end

      // ---- register reads
      if (rd) begin
         prdata_next = '0;
         unique case (paddr)
            tcm_pkg::ADDR_CTRL: begin
               prdata_next[tcm_pkg::CTRL_CS_LSB +: 3] = clock_source_sel_reg;
               prdata_next[tcm_pkg::CTRL_WGM_LSB +: 2] = waveform_mode_sel_reg;
               prdata_next[tcm_pkg::CTRL_COM_LSB +: 2] =
                  compare_output_mode_reg;
               prdata_next[tcm_pkg::CTRL_IE_BIT] = compare_irq_enable_reg;
               prdata_next[tcm_pkg::CTRL_OVIE_BIT] = overflow_irq_enable_reg;
            end
            tcm_pkg::ADDR_COUNT: prdata_next[CNT_W-1:0] = timer_count_reg;
            tcm_pkg::ADDR_COMPARE: prdata_next[CNT_W-1:0] = cpu_cmp;
            tcm_pkg::ADDR_FLAGS: begin
               prdata_next[tcm_pkg::FLAG_CMP_BIT] = compare_flag_reg;
               prdata_next[tcm_pkg::FLAG_OVF_BIT] = overflow_flag_reg;
            end
            tcm_pkg::ADDR_PORT: begin
               prdata_next[tcm_pkg::PORT_VAL_BIT] = port_value_reg;
               prdata_next[tcm_pkg::PORT_DIR_BIT] = compare_pin_direction_reg;
               prdata_next[tcm_pkg::PORT_STATE_BIT] =
                  compare_output_state_reg;
            end
            default: pslverr_next = 1'b1;
         endcase
      end

      // ---- outputs, registered
      compare_irq_next = compare_irq_enable_next && compare_flag_next;
      overflow_irq_next = overflow_irq_enable_next && overflow_flag_next;
      pin_out_next = (compare_output_mode_next != tcm_pkg::COM_NONE) ?
                     compare_output_state_next : port_value_next;
      pin_oe_next = compare_pin_direction_next;
   end

   // ==========================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_source_sel_reg <= tcm_pkg::CS_STOP;
         waveform_mode_sel_reg <= tcm_pkg::WGM_NORMAL;
         compare_output_mode_reg <= tcm_pkg::COM_NONE;
         compare_irq_enable_reg <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         timer_count_reg <= CNT_W'(tcm_pkg::RESET_BYTE);
         compare_value_reg <= CNT_W'(tcm_pkg::RESET_BYTE);
         compare_buf_reg <= CNT_W'(tcm_pkg::RESET_BYTE);
         compare_flag_reg <= 1'b0;
         overflow_flag_reg <= 1'b0;
         compare_output_state_reg <= 1'b0;
         count_down_reg <= 1'b0;
         block_match_reg <= 1'b0;
         match_pend_reg <= 1'b0;
         port_value_reg <= 1'b0;
         compare_pin_direction_reg <= 1'b0;
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         compare_irq_reg <= 1'b0;
         overflow_irq_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         clock_source_sel_reg <= clock_source_sel_next;
         waveform_mode_sel_reg <= waveform_mode_sel_next;
         compare_output_mode_reg <= compare_output_mode_next;
         compare_irq_enable_reg <= compare_irq_enable_next;
         overflow_irq_enable_reg <= overflow_irq_enable_next;
         timer_count_reg <= timer_count_next;
         compare_value_reg <= compare_value_next;
         compare_buf_reg <= compare_buf_next;
         compare_flag_reg <= compare_flag_next;
         overflow_flag_reg <= overflow_flag_next;
         compare_output_state_reg <= compare_output_state_next;
         count_down_reg <= count_down_next;
         block_match_reg <= block_match_next;
         match_pend_reg <= match_pend_next;
         port_value_reg <= port_value_next;
         compare_pin_direction_reg <= compare_pin_direction_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         compare_irq_reg <= compare_irq_next;
         overflow_irq_reg <= overflow_irq_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign compare_irq = compare_irq_reg;
   assign overflow_irq = overflow_irq_reg;
   assign compare_pin_out = pin_out_reg;
   assign compare_pin_oe = pin_oe_reg;
endmodule : tcm_timer

/* File: verif/tcm_monitor.sv */
// Purpose: port-level checks for the timer compare block
// Assumes: apb answer one cycle after the access phase starts
// Notes: bound to every tcm_timer instance
`timescale 1ns/100ps
module tcm_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [7:0] clk_tick_in,
   input wire logic compare_irq_ack,
   input wire logic overflow_irq_ack,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic compare_irq,
   input wire logic overflow_irq,
   input wire logic compare_pin_out,
   input wire logic compare_pin_oe
);
   // ==========================================
   // helpers
   logic acc;
   logic mapped;
   logic wr_port;
   assign acc = psel && penable && !pready;
   assign mapped = paddr inside {tcm_pkg::ADDR_CTRL, tcm_pkg::ADDR_COUNT,
      tcm_pkg::ADDR_COMPARE, tcm_pkg::ADDR_FLAGS, tcm_pkg::ADDR_PORT};
   assign wr_port = acc && pwrite && paddr == tcm_pkg::ADDR_PORT;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // assertions
   a_ready_answer: assert property (acc |=> pready)
      else $error("no answer after access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (acc && !mapped |=> pready && pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (acc && mapped |=> !pslverr)
      else $error("mapped access refused");
   a_rdata_hold: assert property ($changed(prdata) |-> pready)
      else $error("read data changed outside an answer");
   a_dir_cause: assert property ($changed(compare_pin_oe) |->
      $past(wr_port) || $past(wr_port, 2))
      else $error("pin enable changed without port write");
   a_cmp_ack_clear: assert property (compare_irq_ack |=> !compare_irq)
      else $error("compare request kept after service");
   a_ovf_ack_clear: assert property (overflow_irq_ack |=> !overflow_irq)
      else $error("overflow request kept after service");
   c_cmp_irq: cover property ($rose(compare_irq));
   c_ovf_irq: cover property ($rose(overflow_irq));
   c_refused: cover property (pready && pslverr);
   c_pin_move: cover property ($changed(compare_pin_out));
endmodule : tcm_monitor

bind tcm_timer tcm_monitor u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .clk_tick_in(clk_tick_in),
   .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .compare_irq(compare_irq), .overflow_irq(overflow_irq),
   .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe));

/* File: verif/timer8_compare_normal_ctc_tb.sv */
// Purpose: directed apb tests of the timer compare block
// Assumes: prescaler tick on bit 1 every pclk
// Notes: timer counts are inexact here, so waits keep margin
`timescale 1ns/100ps
module timer8_compare_normal_ctc_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] clk_tick_in = 8'h02;
   logic compare_irq_ack = 1'b0;
   logic overflow_irq_ack = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, compare_irq, overflow_irq;
   logic compare_pin_out, compare_pin_oe;
   logic [31:0] rdat;
   logic rerr;
   int err_count = 0;
   int checked = 0;
   int n;
   always #2 pclk = ~pclk;
   tcm_timer #(.CNT_W(8)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .clk_tick_in(clk_tick_in),
      .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compare_irq(compare_irq), .overflow_irq(overflow_irq),
      .compare_pin_out(compare_pin_out), .compare_pin_oe(compare_pin_oe));
   // ==========================================
   // helpers
   function automatic logic [31:0] ctl(input logic [2:0] f,
      input logic [1:0] com, input logic [1:0] wgm, input logic [2:0] cs);
      return {22'h0, f, com, wgm, cs};
   endfunction : ctl
   task fail(input string m);
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) fail("no bus answer");
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rd
   task automatic gap(output int c);
      logic p;
      c = 0;
      p = compare_pin_out;
      while (compare_pin_out === p && c < 50) begin
         @(posedge pclk);
         c++;
      end
   endtask : gap
   task report_and_stop;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #80000;
      fail("watchdog expired");
      report_and_stop;
   end
   // ==========================================
   // tests
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
      rd(8'h14, 32'h0);
      chk(rerr, 1'b1);
      wr(tcm_pkg::ADDR_CTRL, 32'hffff_ff7f);
      rd(tcm_pkg::ADDR_CTRL, 32'h0000_037f);
      for (int m = 0; m < 4; m++) begin
         wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, 2'(m), 3'h0));
         rd(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h1, 2'(m), 3'h0));
         wr(tcm_pkg::ADDR_COMPARE, 32'(m * 16 + 1));
         rd(tcm_pkg::ADDR_COMPARE, 32'(m * 16 + 1));
      end
      // count write while stopped hides the match
      wr(tcm_pkg::ADDR_CTRL, 32'h0);
      wr(tcm_pkg::ADDR_COMPARE, 32'h55);
      wr(tcm_pkg::ADDR_COUNT, 32'h55);
      wr(tcm_pkg::ADDR_FLAGS, 32'h3);
      rd(tcm_pkg::ADDR_COUNT, 32'h55);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'h0, 3'h1));
      rd(tcm_pkg::ADDR_FLAGS, 32'h0);
      // normal wrap and overflow
      wr(tcm_pkg::ADDR_CTRL, 32'h0);
      wr(tcm_pkg::ADDR_COUNT, 32'hfd);
      wr(tcm_pkg::ADDR_COMPARE, 32'h80);
      wr(tcm_pkg::ADDR_FLAGS, 32'h3);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h4, 2'h0, 2'h0, 3'h1));
      repeat (10) @(posedge pclk);
      rd(tcm_pkg::ADDR_FLAGS, 32'h2);
      chk(overflow_irq, 1'b1);
      wr(tcm_pkg::ADDR_FLAGS, 32'h0);
      rd(tcm_pkg::ADDR_FLAGS, 32'h2);
      @(posedge pclk);
      overflow_irq_ack <= 1'b1;
      @(posedge pclk);
      overflow_irq_ack <= 1'b0;
      rd(tcm_pkg::ADDR_FLAGS, 32'h0);
      // ctc toggle, top 3 gives a 4-cycle half period
      wr(tcm_pkg::ADDR_CTRL, 32'h0);
      wr(tcm_pkg::ADDR_COUNT, 32'h0);
      wr(tcm_pkg::ADDR_COMPARE, 32'h3);
      wr(tcm_pkg::ADDR_PORT, 32'h2);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h2, 2'h1, 2'h2, 3'h1));
      repeat (12) @(posedge pclk);
      chk(compare_pin_oe, 1'b1);
      gap(n);
      gap(n);
      chk(n, 32'h4);
      chk(compare_irq, 1'b1);
      compare_irq_ack <= 1'b1;
      @(posedge pclk);
      compare_irq_ack <= 1'b0;
      wr(tcm_pkg::ADDR_FLAGS, 32'h3);
      rd(tcm_pkg::ADDR_FLAGS, 32'h1);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'h2, 3'h1));
      wr(tcm_pkg::ADDR_PORT, 32'h3);
      repeat (2) @(posedge pclk);
      chk(compare_pin_out, 1'b1);
      wr(tcm_pkg::ADDR_PORT, 32'h2);
      repeat (2) @(posedge pclk);
      chk(compare_pin_out, 1'b0);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h3, 2'h2, 3'h1));
      repeat (10) @(posedge pclk);
      chk(compare_pin_out, 1'b1);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h2, 2'h2, 3'h1));
      repeat (10) @(posedge pclk);
      chk(compare_pin_out, 1'b0);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h3, 2'h2, 3'h1));
      repeat (10) @(posedge pclk);
      // state survives the mode change
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h3, 2'h0, 3'h0));
      rd(tcm_pkg::ADDR_PORT, 32'h6);
      // forced match toggles only the output
      wr(tcm_pkg::ADDR_COUNT, 32'h20);
      wr(tcm_pkg::ADDR_FLAGS, 32'h3);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h1, 2'h1, 2'h0, 3'h0));
      repeat (2) @(posedge pclk);
      chk(compare_pin_out, 1'b0);
      rd(tcm_pkg::ADDR_FLAGS, 32'h0);
      rd(tcm_pkg::ADDR_COUNT, 32'h20);
      // ctc top below the count waits for the wrap
      wr(tcm_pkg::ADDR_COUNT, 32'h10);
      wr(tcm_pkg::ADDR_COMPARE, 32'h5);
      wr(tcm_pkg::ADDR_FLAGS, 32'h3);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'h2, 3'h1));
      repeat (40) @(posedge pclk);
      rd(tcm_pkg::ADDR_FLAGS, 32'h0);
      repeat (250) @(posedge pclk);
      rd(tcm_pkg::ADDR_FLAGS, 32'h3);
      // pwm: a new compare waits in the buffer until top
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'h3, 3'h0));
      wr(tcm_pkg::ADDR_COUNT, 32'h0);
      wr(tcm_pkg::ADDR_COMPARE, 32'h40);
      wr(tcm_pkg::ADDR_FLAGS, 32'h3);
      wr(tcm_pkg::ADDR_CTRL, ctl(3'h0, 2'h0, 2'h3, 3'h1));
      repeat (20) @(posedge pclk);
      rd(tcm_pkg::ADDR_FLAGS, 32'h1);
      rd(tcm_pkg::ADDR_COMPARE, 32'h40);
      report_and_stop;
   end
endmodule : timer8_compare_normal_ctc_tb
